//--- rtl/pfc_params.svh
`ifndef PFC_PARAMS_SVH
`define PFC_PARAMS_SVH

////////////////////////////////////////////////////////////////////////////////
// Byte offsets on the host register port
`define PFC_OFS_FRAC_B0 8'h00
`define PFC_OFS_FRAC_B1 8'h01
`define PFC_OFS_FRAC_B2 8'h02
`define PFC_OFS_FRAC_B3 8'h03
`define PFC_OFS_INT_B0 8'h04
`define PFC_OFS_INT_B1 8'h05
`define PFC_OFS_SDM 8'h06
`define PFC_OFS_REFCFG 8'h07
`define PFC_OFS_LPF 8'h08

////////////////////////////////////////////////////////////////////////////////
// Fraction numerator
`define PFC_FRAC_BYTES 4
`define PFC_FRAC_WIDTH 27
`define PFC_FRAC_DENOM_LOG2 27
`define PFC_FRAC_MASK 32'h07FF_FFFF
`define PFC_FRAC_RESET 32'h0000_0000

////////////////////////////////////////////////////////////////////////////////
// Integer divide
`define PFC_INT_BYTES 2
`define PFC_INT_WIDTH 10
`define PFC_INT_MASK 16'h03FF
`define PFC_INT_RESET 16'h006C

////////////////////////////////////////////////////////////////////////////////
// Modulator configuration fields
`define PFC_SDM_ORDER_LSB 0
`define PFC_SDM_GAIN_LSB 2
`define PFC_SDM_SHAPE_BIT 4
`define PFC_SDM_DITHER_BIT 5
`define PFC_SDM_MASK 8'h3F
`define PFC_SDM_RESET 8'h03
`define PFC_STEP_RESET 4'h1
`define PFC_INT_ONLY_RESET 1'b0

////////////////////////////////////////////////////////////////////////////////
// Reference configuration fields
`define PFC_REF_DOUBLER_BIT 0
`define PFC_REF_SEL_BIT 1
`define PFC_REF_MASK 8'h03
`define PFC_REF_RESET 8'h01

////////////////////////////////////////////////////////////////////////////////
// Loop filter fields
`define PFC_LPF_RES_LSB 0
`define PFC_LPF_CAP_LSB 4
`define PFC_LPF_BYP_BIT 7
`define PFC_LPF_MASK 8'hFF
`define PFC_LPF_RESET 8'h76

`endif

//--- rtl/pfc_pkg.sv
package pfc_pkg;

	typedef logic [7:0] pfc_byte_t;

	// Code order matches the field encoding
	typedef enum logic [1:0] {
		PFC_ORDER_INTEGER,
		PFC_ORDER_FIRST,
		PFC_ORDER_SECOND,
		PFC_ORDER_THIRD
	} pfc_order_t;

	typedef enum logic {
		PFC_REF_CRYSTAL,
		PFC_REF_EXTERNAL
	} pfc_ref_t;

	typedef logic [26:0] pfc_frac_t;
	typedef logic [9:0] pfc_int_t;

endpackage : pfc_pkg

//--- rtl/pfc_atomic_reg.sv
`timescale 1ns/1ps

module pfc_atomic_reg #(
	parameter int NBYTES = 2,
	parameter logic [NBYTES*8-1:0] MASK = '1,
	parameter logic [NBYTES*8-1:0] RESET = '0
) (
	// Clock and control
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	// Byte writes
	input wire logic [NBYTES-1:0] byte_we,
	input wire pfc_pkg::pfc_byte_t wr_data,
	// Values
	output logic [NBYTES*8-1:0] staged_value,
	output logic [NBYTES*8-1:0] live_value,
	output logic applied
);
	import pfc_pkg::*;

	logic [NBYTES*8-1:0] stage_reg;
	logic [NBYTES*8-1:0] stage_next;
	logic [NBYTES*8-1:0] live_reg;
	logic [NBYTES*8-1:0] live_next;
	logic applied_reg;
	logic applied_next;

	////////////////////////////////////////////////////////////////////////////////
	// Lower bytes only land in the stage
	genvar i;
	generate
		for (i = 0; i < NBYTES; i++)
		begin : g_byte
			assign stage_next[8*i +: 8] = byte_we[i] ? (wr_data & MASK[8*i +: 8]) : stage_reg[8*i +: 8];
		end
	endgenerate

	// Top byte moves the whole word at once
	always_comb
	begin
		live_next = live_reg;
		applied_next = 1'b0;
		if (byte_we[NBYTES-1])
		begin
			live_next = stage_next;
			applied_next = 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			stage_reg <= RESET & MASK;
			live_reg <= RESET & MASK;
			applied_reg <= 1'b0;
		end
		else if (ce)
		begin
			stage_reg <= stage_next;
			live_reg <= live_next;
			applied_reg <= applied_next;
		end
	end

	assign staged_value = stage_reg;
	assign live_value = live_reg;
	assign applied = applied_reg;

endmodule : pfc_atomic_reg

//--- rtl/pfc_regs.sv
// Contract
// RL1: Hold 27-bit fraction numerator over fixed 2^27 denominator; top five bits reserved.
// RL2: Low fraction bytes are staged; writing bits 31:24 applies whole value at once.
// RL3: Hold 10-bit integer divide in bits 9:0, reset 0x6C, bits 15:10 reserved.
// RL4: Integer low byte is staged; writing bits 15:8 applies new value atomically.
// RL5: Two-bit modulator order: 0 integer, 1..3 first to third order; reset 3.
// RL6: Bit 5 turns modulator dither on when 1; resets to 0.
// RL7: Bit 4 selects unshaped (0) or noise-shaped (1) dither; resets to 0.
// RL8: Bits 3:2 scale dither to one, two, four or eight LSB units.
// RL9: Bit 1 selects crystal reference (0) or external clock input (1); reset 0.
// RL10: Bit 0 enables reference doubler when 1; resets to 1.
// RL11: Loop filter bit 7 bypasses VCO current source filter when 1; reset 0.
// RL12: Bits 6:4 select pole capacitor, 33.3pF to 52.2pF; resets to 7.
// RL13: Bits 3:0 select loop resistor, 0 to 6 kilohm in 400 ohm steps; reset 6.
// RL14: Reserved bits read zero and ignore writes.
// RL15: Host writes lower bytes before the top byte of a multi-byte register.
`timescale 1ns/1ps
`include "pfc_params.svh"

module pfc_regs (
	// Clock, reset, enable
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	// Host register port
	input wire logic csr_wr,
	input wire logic csr_rd,
	input wire pfc_pkg::pfc_byte_t csr_addr,
	input wire pfc_pkg::pfc_byte_t csr_wdata,
	output pfc_pkg::pfc_byte_t csr_rdata,
	output logic csr_rvalid,
	// Feedback divider
	output pfc_pkg::pfc_frac_t fraction_numerator,
	output logic fraction_update,
	output pfc_pkg::pfc_int_t integer_divide_value,
	output logic integer_update,
	// Modulator
	output pfc_pkg::pfc_order_t modulator_order,
	output logic modulator_integer_only,
	output logic dither_on,
	output logic dither_shaping,
	output logic [1:0] dither_amplitude,
	output logic [3:0] dither_step_lsb,
	// Reference
	output pfc_pkg::pfc_ref_t reference_select,
	output logic doubler_on,
	// Loop filter
	output logic vco_filter_bypass,
	output logic [2:0] pole_capacitor_code,
	output logic [3:0] loop_resistor_code
);
	import pfc_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Write decode

	logic [`PFC_FRAC_BYTES-1:0] frac_we;
	logic [`PFC_INT_BYTES-1:0] int_we;
	logic sdm_we;
	logic ref_we;
	logic lpf_we;

	always_comb
	begin
		frac_we = '0;
		int_we = '0;
		sdm_we = 1'b0;
		ref_we = 1'b0;
		lpf_we = 1'b0;
		if (csr_wr)
		begin
			case (csr_addr)
				`PFC_OFS_FRAC_B0: frac_we[0] = 1'b1;
				`PFC_OFS_FRAC_B1: frac_we[1] = 1'b1;
				`PFC_OFS_FRAC_B2: frac_we[2] = 1'b1;
				`PFC_OFS_FRAC_B3: frac_we[3] = 1'b1;
				`PFC_OFS_INT_B0: int_we[0] = 1'b1;
				`PFC_OFS_INT_B1: int_we[1] = 1'b1;
				`PFC_OFS_SDM: sdm_we = 1'b1;
				`PFC_OFS_REFCFG: ref_we = 1'b1;
				`PFC_OFS_LPF: lpf_we = 1'b1;
				// Unmapped writes are dropped
				default: sdm_we = 1'b0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Fraction numerator

	logic [31:0] frac_staged;
	logic [31:0] frac_live;
	logic frac_applied;

	// Only bits 26:0 survive the mask; the loop divides by 2^27
	pfc_atomic_reg #(
		.NBYTES(`PFC_FRAC_BYTES),
		.MASK(`PFC_FRAC_MASK),
		.RESET(`PFC_FRAC_RESET)
	) u_frac (
		.clk(clk),
		.sys_rst(sys_rst),
		.ce(ce),
		.byte_we(frac_we),
		.wr_data(csr_wdata),
		.staged_value(frac_staged),
		.live_value(frac_live),
		.applied(frac_applied)
	); // RL1 RL2 RL14

	////////////////////////////////////////////////////////////////////////////////
	// Integer divide

	logic [15:0] int_staged;
	logic [15:0] int_live;
	logic int_applied;

	pfc_atomic_reg #(
		.NBYTES(`PFC_INT_BYTES),
		.MASK(`PFC_INT_MASK),
		.RESET(`PFC_INT_RESET)
	) u_int (
		.clk(clk),
		.sys_rst(sys_rst),
		.ce(ce),
		.byte_we(int_we),
		.wr_data(csr_wdata),
		.staged_value(int_staged),
		.live_value(int_live),
		.applied(int_applied)
	); // RL3 RL4 RL14

	// Out of order host writes just apply a stale low part
	assign fraction_numerator = frac_live[`PFC_FRAC_WIDTH-1:0]; // RL1
	assign fraction_update = frac_applied; // RL2
	assign integer_divide_value = int_live[`PFC_INT_WIDTH-1:0]; // RL3
	assign integer_update = int_applied; // RL4

	////////////////////////////////////////////////////////////////////////////////
	// Modulator configuration

	pfc_byte_t sdm_reg;
	pfc_byte_t sdm_next;
	logic [3:0] step_reg;
	logic [3:0] step_next;
	logic int_only_reg;
	logic int_only_next;

	always_comb
	begin
		sdm_next = sdm_reg;
		if (sdm_we)
		begin
			sdm_next = csr_wdata & `PFC_SDM_MASK; // RL14
		end
		// Decodes follow the next value, so they switch on the same edge as the field
		step_next = 4'h1 << sdm_next[`PFC_SDM_GAIN_LSB +: 2]; // RL8
		int_only_next = (sdm_next[`PFC_SDM_ORDER_LSB +: 2] == 2'h0); // RL5
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			sdm_reg <= `PFC_SDM_RESET; // RL5 RL6 RL7
			step_reg <= `PFC_STEP_RESET; // RL8
			int_only_reg <= `PFC_INT_ONLY_RESET; // RL5
		end
		else if (ce)
		begin
			sdm_reg <= sdm_next;
			step_reg <= step_next;
			int_only_reg <= int_only_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Reference configuration

	pfc_byte_t ref_reg;
	pfc_byte_t ref_next;

	always_comb
	begin
		ref_next = ref_reg;
		if (ref_we)
		begin
			ref_next = csr_wdata & `PFC_REF_MASK; // RL14
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			ref_reg <= `PFC_REF_RESET; // RL9 RL10
		end
		else if (ce)
		begin
			ref_reg <= ref_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Loop filter configuration

	pfc_byte_t lpf_reg;
	pfc_byte_t lpf_next;

	always_comb
	begin
		lpf_next = lpf_reg;
		if (lpf_we)
		begin
			// Every bit is a live field; the mask keeps all registers alike
			lpf_next = csr_wdata & `PFC_LPF_MASK;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			lpf_reg <= `PFC_LPF_RESET; // RL11 RL12 RL13
		end
		else if (ce)
		begin
			lpf_reg <= lpf_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Field outputs, all straight from registers

	// Modulator
	assign modulator_order = pfc_order_t'(sdm_reg[`PFC_SDM_ORDER_LSB +: 2]); // RL5
	assign modulator_integer_only = int_only_reg; // RL5
	assign dither_on = sdm_reg[`PFC_SDM_DITHER_BIT]; // RL6
	assign dither_shaping = sdm_reg[`PFC_SDM_SHAPE_BIT]; // RL7
	assign dither_amplitude = sdm_reg[`PFC_SDM_GAIN_LSB +: 2]; // RL8
	assign dither_step_lsb = step_reg; // RL8

	// Reference
	assign reference_select = pfc_ref_t'(ref_reg[`PFC_REF_SEL_BIT]); // RL9
	assign doubler_on = ref_reg[`PFC_REF_DOUBLER_BIT]; // RL10

	// Loop filter
	assign vco_filter_bypass = lpf_reg[`PFC_LPF_BYP_BIT]; // RL11
	assign pole_capacitor_code = lpf_reg[`PFC_LPF_CAP_LSB +: 3]; // RL12
	assign loop_resistor_code = lpf_reg[`PFC_LPF_RES_LSB +: 4]; // RL13

	////////////////////////////////////////////////////////////////////////////////
	// Read path, one cycle latency

	pfc_byte_t rd_sel;
	pfc_byte_t rdata_reg;
	pfc_byte_t rdata_next;
	logic rvalid_reg;
	logic rvalid_next;

	// Divider bytes read the staged image, the software view
	always_comb
	begin
		rd_sel = 8'h00;
		case (csr_addr)
			`PFC_OFS_FRAC_B0: rd_sel = frac_staged[7:0];
			`PFC_OFS_FRAC_B1: rd_sel = frac_staged[15:8];
			`PFC_OFS_FRAC_B2: rd_sel = frac_staged[23:16];
			`PFC_OFS_FRAC_B3: rd_sel = frac_staged[31:24];
			`PFC_OFS_INT_B0: rd_sel = int_staged[7:0];
			`PFC_OFS_INT_B1: rd_sel = int_staged[15:8];
			`PFC_OFS_SDM: rd_sel = sdm_reg;
			`PFC_OFS_REFCFG: rd_sel = ref_reg;
			`PFC_OFS_LPF: rd_sel = lpf_reg;
			default: rd_sel = 8'h00; // RL14
		endcase
	end

	always_comb
	begin
		rvalid_next = csr_rd;
		rdata_next = rdata_reg;
		// Data holds between reads so a slow host can still take it
		if (csr_rd)
		begin
			rdata_next = rd_sel;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			rdata_reg <= 8'h00;
			rvalid_reg <= 1'b0;
		end
		else if (ce)
		begin
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
		end
	end

	assign csr_rdata = rdata_reg;
	assign csr_rvalid = rvalid_reg;

endmodule : pfc_regs

//--- test/pfc_regs_props.sv
`timescale 1ns/1ps
module pfc_regs_props (
	// Clock and host port
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire logic csr_wr,
	input wire logic csr_rd,
	input wire pfc_pkg::pfc_byte_t csr_addr,
	input wire pfc_pkg::pfc_byte_t csr_wdata,
	input wire logic csr_rvalid,
	// Loop controls
	input wire pfc_pkg::pfc_frac_t fraction_numerator,
	input wire logic fraction_update,
	input wire pfc_pkg::pfc_int_t integer_divide_value,
	input wire logic integer_update,
	input wire pfc_pkg::pfc_order_t modulator_order,
	input wire logic modulator_integer_only,
	input wire logic dither_on,
	input wire logic dither_shaping,
	input wire logic [1:0] dither_amplitude,
	input wire logic [3:0] dither_step_lsb,
	input wire logic vco_filter_bypass,
	input wire logic [2:0] pole_capacitor_code,
	input wire logic [3:0] loop_resistor_code
);
	import pfc_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	////////////////////////////////////////////////////////////////////////////
	rd_answer_a:
	assert property (ce && csr_rd |=> csr_rvalid) else $error("read not answered");
	frac_apply_a:
	assert property (ce && csr_wr && csr_addr == 8'h03 |=>
		fraction_update && fraction_numerator[26:24] == $past(csr_wdata[2:0])) else $error("fraction not applied");
	frac_hold_a:
	assert property (!fraction_update |-> $stable(fraction_numerator)) else $error("fraction moved early");
	int_apply_a:
	assert property (ce && csr_wr && csr_addr == 8'h05 |=>
		integer_update && integer_divide_value[9:8] == $past(csr_wdata[1:0])) else $error("integer not applied");
	int_hold_a:
	assert property (!integer_update |-> $stable(integer_divide_value)) else $error("integer moved early");
	sdm_write_a:
	assert property (ce && csr_wr && csr_addr == 8'h06 |=>
		{dither_on, dither_shaping, dither_amplitude, modulator_order} == $past(csr_wdata[5:0]))
		else $error("modulator field wrong");
	step_decode_a:
	assert property (dither_step_lsb == 4'h1 << dither_amplitude) else $error("dither step wrong");
	int_only_a:
	assert property (modulator_integer_only == (modulator_order == PFC_ORDER_INTEGER)) else $error("order decode wrong");
	lpf_write_a:
	assert property (ce && csr_wr && csr_addr == 8'h08 |=>
		{vco_filter_bypass, pole_capacitor_code, loop_resistor_code} == $past(csr_wdata)) else $error("filter field wrong");
endmodule : pfc_regs_props

//--- test/pfc_regs_tb.sv
`timescale 1ns/1ps
module pfc_regs_tb;
	import pfc_pkg::*;
	logic clk, sys_rst, ce, csr_wr, csr_rd, csr_rvalid;
	pfc_byte_t csr_addr, csr_wdata, csr_rdata;
	pfc_frac_t fraction_numerator;
	pfc_int_t integer_divide_value;
	pfc_order_t modulator_order;
	pfc_ref_t reference_select;
	logic fraction_update, integer_update, modulator_integer_only, dither_on, dither_shaping;
	logic doubler_on, vco_filter_bypass;
	logic [1:0] dither_amplitude;
	logic [2:0] pole_capacitor_code;
	logic [3:0] dither_step_lsb, loop_resistor_code;
	int fails, n_tests;
	logic [1:0] upd_seen;
	pfc_byte_t rst_map [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h6C, 8'h00, 8'h03, 8'h01, 8'h76, 8'h00};
	pfc_regs dut_u (.*);
	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			fails++;
			$display("unexpected value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : chk
	// Strobe then one idle cycle, so no signal is set twice in a step
	task automatic wr(input pfc_byte_t a, input pfc_byte_t d);
		csr_wr = 1'b1;
		csr_addr = a;
		csr_wdata = d;
		@(posedge clk);
		#1 csr_wr = 1'b0;
		// Update pulses stand only in the cycle after the strobe
		upd_seen = {fraction_update, integer_update};
		@(posedge clk);
		#1;
	endtask : wr
	task automatic rd(input pfc_byte_t a, input pfc_byte_t e);
		csr_rd = 1'b1;
		csr_addr = a;
		@(posedge clk);
		#1 csr_rd = 1'b0;
		chk(csr_rvalid, 1'b1);
		chk(csr_rdata, e);
		@(posedge clk);
		#1 chk(csr_rvalid, 1'b0);
	endtask : rd
	task automatic reset_check;
		for (int i = 0; i < 10; i++)
			rd(8'(i), rst_map[i]);
		chk(fraction_numerator, 27'h000_0000);
		chk(integer_divide_value, 10'h06C);
		chk({dither_on, dither_shaping, dither_amplitude, modulator_order}, 6'h03);
		chk(modulator_integer_only, 1'b0);
		chk({reference_select, doubler_on}, 2'b01);
		chk({vco_filter_bypass, pole_capacitor_code, loop_resistor_code}, 8'h76);
		chk(dither_step_lsb, 4'h1);
	endtask : reset_check
	task automatic close_out;
		if (fails == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : close_out
	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		#50000;
		fails++;
		close_out();
	end
	initial
	begin
		sys_rst = 1'b1;
		ce = 1'b1;
		csr_wr = 1'b0;
		csr_rd = 1'b0;
		csr_addr = 8'h00;
		csr_wdata = 8'h00;
		repeat (20) @(posedge clk);
		#1 sys_rst = 1'b0;
		reset_check();
		// Low bytes only stage; top byte applies the whole
		for (int i = 0; i < 3; i++)
			wr(8'(i), 8'hFF);
		chk(fraction_numerator, 27'h000_0000);
		chk(upd_seen, 2'b00);
		wr(8'h03, 8'hFF);
		chk(upd_seen, 2'b10);
		chk({fraction_update, integer_update}, 2'b00);
		chk(fraction_numerator, 27'h7FF_FFFF);
		rd(8'h03, 8'h07);
		wr(8'h00, 8'h12);
		wr(8'h03, 8'h05);
		chk(fraction_numerator, 27'h5FF_FF12);
		wr(8'h04, 8'hAB);
		chk(upd_seen, 2'b00);
		chk(integer_divide_value, 10'h06C);
		wr(8'h05, 8'hFF);
		chk(upd_seen, 2'b01);
		chk(integer_divide_value, 10'h3AB);
		rd(8'h05, 8'h03);
		// Every order and gain code
		for (int i = 0; i < 4; i++)
		begin
			wr(8'h06, 8'hF0 | 8'(i * 5));
			chk(modulator_order, i);
			chk(modulator_integer_only, i == 0);
			chk(dither_step_lsb, 1 << i);
			chk(dither_amplitude, i);
			chk({dither_on, dither_shaping}, 2'b11);
			rd(8'h06, 8'h30 | 8'(i * 5));
		end
		wr(8'h06, 8'h20);
		chk({dither_on, dither_shaping}, 2'b10);
		wr(8'h07, 8'hFE);
		chk({reference_select, doubler_on}, 2'b10);
		rd(8'h07, 8'h02);
		wr(8'h08, 8'hA5);
		chk({vco_filter_bypass, pole_capacitor_code, loop_resistor_code}, 8'hA5);
		// Frozen while disabled
		ce = 1'b0;
		wr(8'h08, 8'h00);
		ce = 1'b1;
		rd(8'h08, 8'hA5);
		wr(8'h09, 8'hFF);
		rd(8'h09, 8'h00);
		// Two reset cycles so held values settle before checking resumes
		sys_rst = 1'b1;
		repeat (2) @(posedge clk);
		#1 sys_rst = 1'b0;
		reset_check();
		close_out();
	end
endmodule : pfc_regs_tb

bind pfc_regs pfc_regs_props chk_u (.*);
